// ==== inc/csd_pkg.sv ====
// Constants, types and helpers shared by the channel sense detector
package csd_pkg;
  localparam int CLK_PERIOD_NS   = 4;
  localparam int SAR_SETTLE_NS   = 32;
  localparam int SAR_STEP_CYCLES = (SAR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int JUMP_GAP_NS     = 4096;
  localparam int JUMP_GAP_CYCLES = JUMP_GAP_NS / CLK_PERIOD_NS;

  localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
  localparam logic [31:0] ADDR_THRESH = 32'h0000_0004;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;

  localparam int CTRL_ORDER_LSB  = 0;
  localparam int CTRL_REPORT_LSB = 4;
  localparam int CTRL_WIN_LSB    = 8;
  localparam int CTRL_MUTE_BIT   = 12;
  localparam int CTRL_DIRECT_BIT = 13;
  localparam int CTRL_IRQ_STR    = 16;
  localparam int CTRL_IRQ_JMP    = 17;
  localparam int CTRL_EXT_STR    = 20;
  localparam int CTRL_EXT_JMP    = 21;
  localparam int CTRL_SLP_BIT    = 24;
  localparam int THR_LSB         = 0;
  localparam int DBM_OFF_LSB     = 8;
  localparam int ST_CODE_LSB     = 0;
  localparam int ST_DBM_LSB      = 8;
  localparam int ST_ABOVE_BIT    = 16;
  localparam int ST_WANTED_BIT   = 17;

  localparam logic [31:0] CTRL_RESET   = 32'h0000_0200;
  localparam logic [31:0] CTRL_WMASK   = 32'h0133_3337;
  localparam logic [31:0] THRESH_RESET = 32'h0000_0000;
  localparam logic [31:0] THRESH_WMASK = 32'h0000_FFFF;
  localparam logic [7:0]  SAR_START    = 8'h80;
  localparam logic [2:0]  SAR_TOP_BIT  = 3'h7;

  typedef enum logic [1:0] {RepRealTime, RepPreamble, RepSync, RepPacket} csd_report_t;
  typedef enum logic {SarChanI, SarChanQ} csd_sar_t;

  // Saturate rather than wrap so a strong signal never reads as weak
  function automatic logic [7:0] f_sat_sum(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    f_sat_sum = s[8] ? 8'hFF : s[7:0];
  endfunction

  // Half-step per code minus a software offset
  function automatic logic [7:0] f_to_dbm(input logic [7:0] code, input logic [7:0] offs);
    f_to_dbm = {1'b0, code[7:1]} - offs;
  endfunction

  function automatic logic [3:0] f_jump_need(input logic [1:0] sel);
    unique case (sel)
      2'h0: f_jump_need = 4'h1;
      2'h1: f_jump_need = 4'h2;
      2'h2: f_jump_need = 4'h4;
      2'h3: f_jump_need = 4'h8;
    endcase
  endfunction
endpackage

// ==== core/csd_avg_filter.sv ====
// Exponential averaging filter of selectable order
`timescale 1ns/1ns
module csd_avg_filter (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       sampleValid,
  input  wire logic [7:0] sampleIn,
  input  wire logic [2:0] order,
  output logic [7:0]      filtOut
);
  logic [15:0]       acc_q, acc_d;
  logic signed [16:0] diff, step, accSum;

  always_comb begin
    diff   = $signed({1'b0, sampleIn, 8'h00}) - $signed({1'b0, acc_q});
    step   = diff >>> order;
    accSum = $signed({1'b0, acc_q}) + step;
    acc_d  = sampleValid ? accSum[15:0] : acc_q;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_q <= 16'h0000;
    end else begin
      acc_q <= acc_d;
    end
  end

  assign filtOut = acc_q[15:8];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_order_zero: assert property (sampleValid && order == 3'h0 |=> filtOut == $past(sampleIn))
    else $error("order zero does not pass sample");
  a_idle_hold: assert property (!sampleValid |=> $stable(filtOut))
    else $error("filter moved without sample");
endmodule

// ==== core/csd_phase_jump.sv ====
// Phase-jump detector qualifying FSK signals
`timescale 1ns/1ns
module csd_phase_jump (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       fskMode,
  input  wire logic       dataIn,
  input  wire logic       deviationOk,
  input  wire logic       snrOk,
  input  wire logic [1:0] jumpWindowSelect,
  output logic            wanted
);
  localparam logic [10:0] GAP_LAST = 11'(csd_pkg::JUMP_GAP_CYCLES - 1);
  logic        prev_q, prev_d, wanted_q, wanted_d, jump;
  logic [3:0]  jumps_q, jumps_d;
  logic [10:0] gap_q, gap_d;

  always_comb begin
    prev_d  = dataIn;
    jump    = dataIn != prev_q;
    jumps_d = jumps_q;
    gap_d   = gap_q;
    if (!fskMode) begin
      jumps_d = 4'h0;
      gap_d   = 11'h000;
    end else if (jump) begin
      gap_d   = 11'h000;
      jumps_d = (jumps_q == 4'hF) ? jumps_q : jumps_q + 4'h1;
    end else if (gap_q == GAP_LAST) begin
      // Long silence means the jump rate is not the expected one
      jumps_d = 4'h0;
    end else begin
      gap_d = gap_q + 11'h001;
    end
    wanted_d = fskMode && deviationOk && snrOk
               && (jumps_d >= csd_pkg::f_jump_need(jumpWindowSelect));
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prev_q   <= 1'b0;
      jumps_q  <= 4'h0;
      gap_q    <= 11'h000;
      wanted_q <= 1'b0;
    end else begin
      prev_q   <= prev_d;
      jumps_q  <= jumps_d;
      gap_q    <= gap_d;
      wanted_q <= wanted_d;
    end
  end

  assign wanted = wanted_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_wanted_qual: assert property ($rose(wanted) |-> $past(deviationOk && snrOk && fskMode))
    else $error("wanted without deviation or SNR");
  a_fsk_only: assert property (!fskMode |=> !wanted)
    else $error("wanted outside FSK");
  a_jump_need: assert property ($rose(wanted) |-> jumps_q >= csd_pkg::f_jump_need($past(jumpWindowSelect)))
    else $error("wanted before enough jumps");
endmodule

// ==== core/csd_top.sv ====
// Channel sense detector: converter, filters, threshold, jump detector, AHB-Lite registers
`timescale 1ns/1ns
module csd_top (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        sarCompIn,
  output logic [7:0]       sarTrialCode,
  output logic             sarChanQ,
  input  wire logic        fskMode,
  input  wire logic        demodData,
  input  wire logic        deviationOk,
  input  wire logic        snrOk,
  input  wire logic        preambleFound,
  input  wire logic        syncFound,
  input  wire logic        packetDone,
  output logic             dataOut,
  output logic             validSignalInterrupt,
  output logic             rxExtend
);
  localparam logic [3:0] STEP_LAST = 4'(csd_pkg::SAR_STEP_CYCLES - 1);

  // Register file
  logic [31:0] ctrl_q, ctrl_d, thresh_q, thresh_d, hrdata_q, hrdata_d, wrAddr_q, wrAddr_d;
  logic        wrPend_q, wrPend_d, addrPhase;
  // Converter
  logic        cs1_q, cs2_q, cs3_q, compStable_q, compStable_d;
  logic [3:0]  stepCnt_q, stepCnt_d;
  logic        stepEn;
  logic [7:0]  trial_q, trial_d, iVal_q, iVal_d, sum_q, sum_d, mask, res;
  logic [2:0]  idx_q, idx_d;
  csd_pkg::csd_sar_t chan_q, chan_d;
  logic        sumValid_q, sumValid_d;
  // Filters and reporting
  logic [7:0]  prevSum_q, prevSum_d, cfOut_q, cfOut_d, filtCode, report_q, report_d;
  logic [8:0]  cfSum;
  logic        cfValid_q, cfValid_d, selEvent;
  logic        above_q, above_d, wanted;
  logic        irq_q, irq_d, ext_q, ext_d, dout_q, dout_d;
  // Control fields
  logic [2:0]  strengthAverageOrder;
  logic [1:0]  jumpWindowSelect;
  logic [7:0]  strengthThreshold, dbmOffset, strengthDbmValue;
  logic        muteEnable, directMode, superLowPowerMode;
  csd_pkg::csd_report_t strengthReportSelect;

  assign strengthAverageOrder = ctrl_q[csd_pkg::CTRL_ORDER_LSB +: 3];
  assign strengthReportSelect = csd_pkg::csd_report_t'(ctrl_q[csd_pkg::CTRL_REPORT_LSB +: 2]);
  assign jumpWindowSelect     = ctrl_q[csd_pkg::CTRL_WIN_LSB +: 2];
  assign muteEnable           = ctrl_q[csd_pkg::CTRL_MUTE_BIT];
  assign directMode           = ctrl_q[csd_pkg::CTRL_DIRECT_BIT];
  assign superLowPowerMode    = ctrl_q[csd_pkg::CTRL_SLP_BIT];
  assign strengthThreshold    = thresh_q[csd_pkg::THR_LSB +: 8];
  assign dbmOffset            = thresh_q[csd_pkg::DBM_OFF_LSB +: 8];
  assign strengthDbmValue     = csd_pkg::f_to_dbm(report_q, dbmOffset);

  // AHB-Lite slave, zero wait state
  assign addrPhase = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  always_comb begin
    ctrl_d   = ctrl_q;
    thresh_d = thresh_q;
    if (wrPend_q && wrAddr_q == csd_pkg::ADDR_CTRL) begin
      ctrl_d = hwdata & csd_pkg::CTRL_WMASK;
    end
    if (wrPend_q && wrAddr_q == csd_pkg::ADDR_THRESH) begin
      thresh_d = hwdata & csd_pkg::THRESH_WMASK;
    end
    wrPend_d = addrPhase && hwrite;
    wrAddr_d = addrPhase ? haddr : wrAddr_q;
    hrdata_d = hrdata_q;
    // Read takes the forwarded value so a read right after a write sees it
    if (addrPhase && !hwrite) begin
      unique case (haddr)
        csd_pkg::ADDR_CTRL:   hrdata_d = ctrl_d;
        csd_pkg::ADDR_THRESH: hrdata_d = thresh_d;
        csd_pkg::ADDR_STATUS: hrdata_d = {14'h0000, wanted, above_q,
                                          strengthDbmValue, report_q};
        default:              hrdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_q   <= csd_pkg::CTRL_RESET;
      thresh_q <= csd_pkg::THRESH_RESET;
      wrPend_q <= 1'b0;
      wrAddr_q <= 32'h0000_0000;
      hrdata_q <= 32'h0000_0000;
    end else begin
      ctrl_q   <= ctrl_d;
      thresh_q <= thresh_d;
      wrPend_q <= wrPend_d;
      wrAddr_q <= wrAddr_d;
      hrdata_q <= hrdata_d;
    end
  end

  // Comparator synchroniser; a level counts once stages two and three agree
  always_comb begin
    compStable_d = (cs2_q == cs3_q) ? cs2_q : compStable_q;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cs1_q        <= 1'b0;
      cs2_q        <= 1'b0;
      cs3_q        <= 1'b0;
      compStable_q <= 1'b0;
    end else begin
      cs1_q        <= sarCompIn;
      cs2_q        <= cs1_q;
      cs3_q        <= cs2_q;
      compStable_q <= compStable_d;
    end
  end

  // Successive approximation, I then Q, one bit per settle step
  assign stepEn = stepCnt_q == STEP_LAST;

  always_comb begin
    stepCnt_d  = stepEn ? 4'h0 : stepCnt_q + 4'h1;
    trial_d    = trial_q;
    idx_d      = idx_q;
    chan_d     = chan_q;
    iVal_d     = iVal_q;
    sum_d      = sum_q;
    sumValid_d = 1'b0;
    mask       = 8'h01 << idx_q;
    res        = compStable_q ? trial_q : (trial_q & ~mask);
    if (stepEn) begin
      if (idx_q != 3'h0) begin
        trial_d = res | (mask >> 1);
        idx_d   = idx_q - 3'h1;
      end else begin
        trial_d = csd_pkg::SAR_START;
        idx_d   = csd_pkg::SAR_TOP_BIT;
        unique case (chan_q)
          csd_pkg::SarChanI: begin
            iVal_d = res;
            chan_d = csd_pkg::SarChanQ;
          end
          csd_pkg::SarChanQ: begin
            sum_d      = csd_pkg::f_sat_sum(iVal_q, res);
            sumValid_d = 1'b1;
            chan_d     = csd_pkg::SarChanI;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stepCnt_q  <= 4'h0;
      trial_q    <= csd_pkg::SAR_START;
      idx_q      <= csd_pkg::SAR_TOP_BIT;
      chan_q     <= csd_pkg::SarChanI;
      iVal_q     <= 8'h00;
      sum_q      <= 8'h00;
      sumValid_q <= 1'b0;
    end else begin
      stepCnt_q  <= stepCnt_d;
      trial_q    <= trial_d;
      idx_q      <= idx_d;
      chan_q     <= chan_d;
      iVal_q     <= iVal_d;
      sum_q      <= sum_d;
      sumValid_q <= sumValid_d;
    end
  end

  assign sarTrialCode = trial_q;
  assign sarChanQ     = chan_q == csd_pkg::SarChanQ;

  // Converter filter: two-tap mean of successive sums
  always_comb begin
    cfSum     = {1'b0, prevSum_q} + {1'b0, sum_q};
    prevSum_d = sumValid_q ? sum_q : prevSum_q;
    cfOut_d   = sumValid_q ? cfSum[8:1] : cfOut_q;
    cfValid_d = sumValid_q;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prevSum_q <= 8'h00;
      cfOut_q   <= 8'h00;
      cfValid_q <= 1'b0;
    end else begin
      prevSum_q <= prevSum_d;
      cfOut_q   <= cfOut_d;
      cfValid_q <= cfValid_d;
    end
  end

  csd_avg_filter u_avg (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .sampleValid (cfValid_q),
    .sampleIn    (cfOut_q),
    .order       (strengthAverageOrder),
    .filtOut     (filtCode)
  );

  csd_phase_jump u_jump (
    .ref_clk          (ref_clk),
    .rst_n            (rst_n),
    .fskMode          (fskMode),
    .dataIn           (demodData),
    .deviationOk      (deviationOk),
    .snrOk            (snrOk),
    .jumpWindowSelect (jumpWindowSelect),
    .wanted           (wanted)
  );

  // Reporting, threshold and source selection
  always_comb begin
    unique case (strengthReportSelect)
      csd_pkg::RepRealTime: selEvent = 1'b1;
      csd_pkg::RepPreamble: selEvent = preambleFound;
      csd_pkg::RepSync:     selEvent = syncFound;
      csd_pkg::RepPacket:   selEvent = packetDone;
    endcase
    report_d = selEvent ? filtCode : report_q;
    above_d  = filtCode > strengthThreshold;
    irq_d    = (ctrl_q[csd_pkg::CTRL_IRQ_STR] && above_q)
               || (ctrl_q[csd_pkg::CTRL_IRQ_JMP] && wanted);
    ext_d    = superLowPowerMode && ((ctrl_q[csd_pkg::CTRL_EXT_STR] && above_q)
               || (ctrl_q[csd_pkg::CTRL_EXT_JMP] && wanted));
    // Muting forces zero so a listener sees a quiet line, not noise
    dout_d   = (directMode && muteEnable && !wanted) ? 1'b0 : demodData;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      report_q <= 8'h00;
      above_q  <= 1'b0;
      irq_q    <= 1'b0;
      ext_q    <= 1'b0;
      dout_q   <= 1'b0;
    end else begin
      report_q <= report_d;
      above_q  <= above_d;
      irq_q    <= irq_d;
      ext_q    <= ext_d;
      dout_q   <= dout_d;
    end
  end

  assign validSignalInterrupt = irq_q;
  assign rxExtend             = ext_q;
  assign dataOut              = dout_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_sar_step: assert property (stepEn |=> !stepEn [*7] ##1 stepEn)
    else $error("converter step spacing wrong");
  a_sum_floor: assert property (sumValid_q |-> sum_q >= iVal_q)
    else $error("sum below in-phase part");
  a_real_follow: assert property (strengthReportSelect == csd_pkg::RepRealTime
                                  |=> report_q == $past(filtCode))
    else $error("real-time report lags");
  a_latch_hold: assert property (!selEvent |=> $stable(report_q))
    else $error("latched report changed without event");
  a_thresh_cmp: assert property (filtCode > strengthThreshold |=> above_q)
    else $error("threshold compare missed");
  a_thresh_low: assert property (filtCode <= strengthThreshold |=> !above_q)
    else $error("threshold compare false high");
  a_irq_source: assert property (ctrl_q[csd_pkg::CTRL_IRQ_STR] && above_q
                                 |=> validSignalInterrupt)
    else $error("strength source not on interrupt");
  a_ext_gate: assert property (!superLowPowerMode |=> !rxExtend)
    else $error("extension outside low-power mode");
  a_mute_data: assert property (directMode && muteEnable && !wanted |=> !dataOut)
    else $error("data not muted");

  c_wanted_rise: cover property ($rose(wanted));
  c_latched_update: cover property (strengthReportSelect == csd_pkg::RepSync && syncFound);
  c_mute_active: cover property (directMode && muteEnable && !wanted && demodData);
  c_above_rise: cover property ($rose(above_q));
endmodule

// ==== sim/csd_afe_model.sv ====
// Analog front end model: per-channel strength levels and the converter comparator
`timescale 1ns/1ns
module csd_afe_model (
  input  wire logic [7:0] sarTrialCode,
  input  wire logic       sarChanQ,
  input  wire logic [7:0] levelI,
  input  wire logic [7:0] levelQ,
  output logic            sarCompIn
);
  // Answers at once; the design resynchronises, so no settling delay is modelled
  always_comb begin
    sarCompIn = ((sarChanQ ? levelQ : levelI) >= sarTrialCode);
  end
endmodule

// ==== sim/channel_sense_detector_tb_top.sv ====
// Testbench for the channel sense detector, driven over AHB-Lite
`timescale 1ns/1ns
module channel_sense_detector_tb_top;
  logic        ref_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, sarCompIn, sarChanQ;
  logic        fskMode, demodData, deviationOk, snrOk, preambleFound, syncFound, packetDone;
  logic        dataOut, validSignalInterrupt, rxExtend;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  sarTrialCode, levelI, levelQ;
  int          failures, totalChecks;

  assign hready = hreadyout;

  csd_top i_csd_top (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sarCompIn(sarCompIn),
    .sarTrialCode(sarTrialCode), .sarChanQ(sarChanQ), .fskMode(fskMode),
    .demodData(demodData), .deviationOk(deviationOk), .snrOk(snrOk),
    .preambleFound(preambleFound), .syncFound(syncFound), .packetDone(packetDone),
    .dataOut(dataOut), .validSignalInterrupt(validSignalInterrupt), .rxExtend(rxExtend)
  );

  csd_afe_model i_csd_afe_model (
    .sarTrialCode(sarTrialCode), .sarChanQ(sarChanQ), .levelI(levelI), .levelQ(levelQ),
    .sarCompIn(sarCompIn)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Bounded wait for hready at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) begin
      failures++;
      stop_test();
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  // Polls until the code settles, then rereads once the flags have caught up
  task automatic poll(input logic [7:0] e);
    int n;
    n = 0;
    do begin
      cyc(32);
      ahb(1'b0, csd_pkg::ADDR_STATUS, 32'h0);
      n++;
    end while (rd[7:0] !== e && n < 60);
    cyc(4);
    rdchk("strength code", csd_pkg::ADDR_STATUS, {rd[31:8], e});
  endtask

  task automatic pulse(input int k);
    preambleFound <= (k == 1);
    syncFound     <= (k == 2);
    packetDone    <= (k == 3);
    cyc(1);
    preambleFound <= 1'b0;
    syncFound     <= 1'b0;
    packetDone    <= 1'b0;
    cyc(3);
  endtask

  task automatic toggle(input int n);
    repeat (n) begin
      demodData <= ~demodData;
      cyc(10);
    end
  endtask

  task automatic fsk_restart();
    fskMode <= 1'b0;
    cyc(4);
    fskMode <= 1'b1;
    cyc(2);
  endtask

  task automatic wanted_chk(input string nm, input logic e);
    ahb(1'b0, csd_pkg::ADDR_STATUS, 32'h0);
    chk(nm, {31'h0, e}, {31'h0, rd[csd_pkg::ST_WANTED_BIT]});
  endtask

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    fskMode = 1'b0;
    demodData = 1'b0;
    deviationOk = 1'b1;
    snrOk = 1'b1;
    preambleFound = 1'b0;
    syncFound = 1'b0;
    packetDone = 1'b0;
    levelI = 8'h30;
    levelQ = 8'h20;
    failures = 0;
    totalChecks = 0;
    cyc(20);
    rst_n <= 1'b1;
    cyc(2);
    chk("idle outputs", 32'h0, {28'h0, dataOut, validSignalInterrupt, rxExtend, hresp});
    rdchk("ctrl reset", csd_pkg::ADDR_CTRL, csd_pkg::CTRL_RESET);
    rdchk("thresh reset", csd_pkg::ADDR_THRESH, csd_pkg::THRESH_RESET);
    ahb(1'b1, csd_pkg::ADDR_CTRL, 32'hFFFF_FFFF);
    rdchk("ctrl mask", csd_pkg::ADDR_CTRL, 32'h0133_3337);
    ahb(1'b1, csd_pkg::ADDR_THRESH, 32'hFFFF_FFFF);
    rdchk("thresh mask", csd_pkg::ADDR_THRESH, 32'h0000_FFFF);
    ahb(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
    rdchk("unmapped", 32'h0000_0010, 32'h0);
    // Strength path, threshold strictly greater, dBm wrap, saturation
    ahb(1'b1, csd_pkg::ADDR_THRESH, 32'h0000_104F);
    ahb(1'b1, csd_pkg::ADDR_CTRL, 32'h0111_0000);
    poll(8'h50);
    chk("status", 32'h0001_1850, rd);
    chk("irq ext on", 32'h3, {30'h0, validSignalInterrupt, rxExtend});
    ahb(1'b1, csd_pkg::ADDR_THRESH, 32'h0000_3050);
    cyc(4);
    rdchk("status equal", csd_pkg::ADDR_STATUS, 32'h0000_F850);
    chk("irq ext off", 32'h0, {30'h0, validSignalInterrupt, rxExtend});
    levelI <= 8'hC0;
    levelQ <= 8'h80;
    poll(8'hFF);
    chk("status saturated", 32'h0001_4FFF, rd);
    // A high order slows the averager's step response
    ahb(1'b1, csd_pkg::ADDR_CTRL, 32'h0111_0003);
    levelI <= 8'h30;
    levelQ <= 8'h20;
    cyc(384);
    ahb(1'b0, csd_pkg::ADDR_STATUS, 32'h0);
    chk("slow average", 32'h1, {31'h0, rd[7:0] > 8'h90});
    ahb(1'b1, csd_pkg::ADDR_CTRL, 32'h0111_0000);
    poll(8'h50);
    // Latched reporting: each event source, a wrong event holds the value
    for (int m = 1; m <= 3; m++) begin
      ahb(1'b1, csd_pkg::ADDR_CTRL, 32'(m) << csd_pkg::CTRL_REPORT_LSB);
      pulse(m);
      rdchk("latched", csd_pkg::ADDR_STATUS, 32'h0000_F850);
      levelI <= 8'h10;
      levelQ <= 8'h10;
      cyc(640);
      rdchk("held", csd_pkg::ADDR_STATUS, 32'h0000_F850);
      pulse(m % 3 + 1);
      rdchk("held other", csd_pkg::ADDR_STATUS, 32'h0000_F850);
      pulse(m);
      rdchk("relatched", csd_pkg::ADDR_STATUS, 32'h0000_E020);
      levelI <= 8'h30;
      levelQ <= 8'h20;
      cyc(640);
    end
    // Jump detector over every window, muted direct data
    for (int w = 0; w < 4; w++) begin
      ahb(1'b1, csd_pkg::ADDR_CTRL, 32'h0122_3000 | (32'(w) << 8));
      fsk_restart();
      toggle((1 << w) - 1);
      wanted_chk("wanted early", 1'b0);
      chk("muted data", 32'h0, {31'h0, dataOut});
      toggle(1);
      wanted_chk("wanted", 1'b1);
      chk("jump outs", {29'h0, 2'h3, demodData}, {29'h0, validSignalInterrupt, rxExtend,
          dataOut});
    end
    snrOk <= 1'b0;
    cyc(2);
    wanted_chk("low snr", 1'b0);
    snrOk <= 1'b1;
    deviationOk <= 1'b0;
    fsk_restart();
    toggle(8);
    wanted_chk("bad deviation", 1'b0);
    deviationOk <= 1'b1;
    ahb(1'b1, csd_pkg::ADDR_CTRL, 32'h0122_2200);
    fsk_restart();
    toggle(1);
    chk("unmuted data", {31'h0, demodData}, {31'h0, dataOut});
    toggle(3);
    wanted_chk("four jumps", 1'b1);
    cyc(csd_pkg::JUMP_GAP_CYCLES - 100);
    wanted_chk("before gap", 1'b1);
    cyc(200);
    wanted_chk("after gap", 1'b0);
    stop_test();
  end
endmodule
